/* verilog/secure_startup_cfg.svh */
// Constants for the secure startup sequencer: positions, offsets and reset values.
`ifndef SECURE_STARTUP_CFG_SVH
`define SECURE_STARTUP_CFG_SVH
`define SSI_BLOCK_MASK 32'hFFFF0000
`define SSI_BLOCK_SIZE 32'h00010000
`define SSI_CODE_SEL 16'h0008
`define SSI_STACK_SEL 16'h0010
`define SSI_SEG_BASE 32'h00000000
`define SSI_SEG_LIMIT 32'hFFFFFFFF
`define SSI_VCR_DPD_BIT 0
`define SSI_VCR_RINIT_BIT 1
`define SSI_VCR_A20_BIT 2
`define SSI_VCR_SET_MASK 5'h07
`define SSI_VCR_RESET 5'h00
`define SSI_MODEL_INFO 32'h00000F00
`define SSI_RAM_AW 14
`define SSI_ENTRY_WORD 14'h0000
`endif

/* verilog/secure_startup_pkg.sv */
// Types shared by the secure startup sequencer.
package secure_startup_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_REINIT = 4'b0001,
    ST_PROTECT = 4'b0010,
    ST_HANDSHAKE = 4'b0011,
    ST_HDR = 4'b0100,
    ST_XFER = 4'b0101,
    ST_SIGNAL = 4'b0110,
    ST_GATE = 4'b0111,
    ST_STACK = 4'b1000,
    ST_JUMP = 4'b1001,
    ST_DONE = 4'b1010
  } seq_state_t;
  typedef struct packed {
    logic valid;
    logic start;
    logic finish;
    logic [31:0] data;
  } tpm_tx_t;
  typedef struct packed {
    logic [15:0] code_sel;
    logic [15:0] stack_sel;
    logic [31:0] seg_base;
    logic [31:0] seg_limit;
    logic flat32;
    logic paging;
    logic data_segs_real16;
  } mode_t;
endpackage

/* verilog/loader_image_ram.sv */
// Word memory holding the loader block image as seen by the sequencer.
`timescale 1ns/10ps
`include "secure_startup_cfg.svh"
module loader_image_ram (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [`SSI_RAM_AW-1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [`SSI_RAM_AW-1:0] i_raddr,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:(1<<`SSI_RAM_AW)-1];
  // Write port and registered read port.
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

/* verilog/secure_startup_seq.sv */
// Secure startup sequencer: processor-side steps of the secure startup instruction.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "secure_startup_cfg.svh"
module secure_startup_seq
  import secure_startup_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [31:0] i_accumulator,
  input wire logic i_multi_proc,
  input wire logic i_handshake_done,
  input wire logic i_tpm_ready,
  input wire logic i_img_we,
  input wire logic [`SSI_RAM_AW-1:0] i_img_waddr,
  input wire logic [31:0] i_img_wdata,
  input wire logic i_gate_set,
  input wire logic i_vcr_we,
  input wire logic [4:0] i_vcr_wdata,
  input wire logic i_shutdown,
  input wire logic i_irq_req,
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_accumulator,
  output logic [31:0] o_data_reg,
  output logic [31:0] o_stack_ptr,
  output logic [31:0] o_gpr_clear,
  output logic [31:0] o_jump_addr,
  output logic o_jump,
  output logic o_ext_feature_clear,
  output mode_t o_mode,
  output logic [4:0] o_vcr,
  output logic o_dev_protect_en,
  output logic [31:0] o_dev_protect_base,
  output logic o_handshake_req,
  output tpm_tx_t o_tpm,
  output logic o_gate,
  output logic o_irq_held,
  output logic o_irq_deliver,
  output logic o_debug_port_off,
  output logic o_a20_mask_off,
  output logic o_init_redirect,
  output logic o_halted,
  output logic o_trap_suppress
);
  // ==========================================================
  // State
  // ==========================================================
  seq_state_t state_q;
  seq_state_t state_d;
  logic [31:0] base_q;
  logic [15:0] entry_q;
  logic [15:0] len_q;
  logic [`SSI_RAM_AW-1:0] raddr_q;
  logic [15:0] sent_q;
  logic rd_pend_q;
  logic [31:0] rdata;
  logic tx_fire;

  loader_image_ram u_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(i_img_we),
    .i_waddr(i_img_waddr),
    .i_wdata(i_img_wdata),
    .i_raddr(raddr_q),
    .o_rdata(rdata)
  );

  // A word is sent once its read has landed and the module accepts it.
  assign tx_fire = (state_q == ST_XFER) && rd_pend_q && i_tpm_ready;

  // ==========================================================
  // Step sequencing
  // ==========================================================
  // Next step; each step completes before the next one starts.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (i_start && !o_halted) begin
          state_d = ST_REINIT;
        end
      end
      ST_REINIT: state_d = ST_PROTECT;
      ST_PROTECT: state_d = ST_HANDSHAKE;
      ST_HANDSHAKE: begin
        if (!i_multi_proc || i_handshake_done) begin
          state_d = ST_HDR;
        end
      end
      ST_HDR: begin
        if (rd_pend_q) begin
          state_d = ST_XFER;
        end
      end
      ST_XFER: begin
        if (tx_fire && ({1'b0, sent_q} + 17'h00004 >= {1'b0, len_q})) begin
          state_d = ST_SIGNAL;
        end
      end
      ST_SIGNAL: begin
        if (i_tpm_ready) begin
          state_d = ST_GATE;
        end
      end
      ST_GATE: state_d = ST_STACK;
      ST_STACK: state_d = ST_JUMP;
      ST_JUMP: state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Architectural register effects
  // ==========================================================
  // Start latches the base; reinit clears GPRs; protect loads the base into the accumulator; stack and jump finish up.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      base_q <= 32'h00000000;
      o_accumulator <= 32'h00000000;
      o_data_reg <= 32'h00000000;
      o_stack_ptr <= 32'h00000000;
      o_gpr_clear <= 32'h00000000;
      o_jump_addr <= 32'h00000000;
      o_jump <= 1'b0;
      o_ext_feature_clear <= 1'b0;
      o_trap_suppress <= 1'b0;
    end else begin
      o_jump <= 1'b0;
      o_ext_feature_clear <= 1'b0;
      if (state_q == ST_IDLE && state_d == ST_REINIT) begin
        base_q <= i_accumulator & `SSI_BLOCK_MASK;
        o_trap_suppress <= 1'b1;
      end
      if (state_q == ST_REINIT) begin
        o_gpr_clear <= 32'hFFFFFFFF;
        o_data_reg <= `SSI_MODEL_INFO;
        o_stack_ptr <= 32'h00000000;
        o_ext_feature_clear <= 1'b1;
      end
      if (state_q == ST_PROTECT) begin
        o_accumulator <= base_q;
      end
      if (state_q == ST_STACK) begin
        o_stack_ptr <= base_q + `SSI_BLOCK_SIZE;
      end
      if (state_q == ST_JUMP) begin
        o_jump_addr <= base_q + {16'h0000, entry_q};
        o_jump <= 1'b1;
        o_gpr_clear <= 32'h00000000;
        o_trap_suppress <= 1'b0;
      end
    end
  end

  // Flat protected mode with real-mode data segments after reinit.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mode <= '0;
    end else if (state_q == ST_REINIT) begin
      o_mode.code_sel <= `SSI_CODE_SEL;
      o_mode.stack_sel <= `SSI_STACK_SEL;
      o_mode.seg_base <= `SSI_SEG_BASE;
      o_mode.seg_limit <= `SSI_SEG_LIMIT;
      o_mode.flat32 <= 1'b1;
      o_mode.paging <= 1'b0;
      o_mode.data_segs_real16 <= 1'b1;
    end
  end

  // ==========================================================
  // Virtualization control register
  // ==========================================================
  // Startup forces three flags; software may rewrite all five bits later.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_vcr <= `SSI_VCR_RESET;
    end else if (state_q == ST_REINIT) begin
      o_vcr <= o_vcr | `SSI_VCR_SET_MASK;
    end else if (i_vcr_we) begin
      o_vcr <= i_vcr_wdata;
    end
  end

  // Flag decodes that steer debug, A20 and warm-restart handling.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_debug_port_off <= 1'b0;
      o_init_redirect <= 1'b0;
      o_a20_mask_off <= 1'b0;
    end else begin
      o_debug_port_off <= o_vcr[`SSI_VCR_DPD_BIT];
      o_init_redirect <= o_vcr[`SSI_VCR_RINIT_BIT];
      o_a20_mask_off <= o_vcr[`SSI_VCR_A20_BIT];
    end
  end

  // ==========================================================
  // Block protection and handshake
  // ==========================================================
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dev_protect_en <= 1'b0;
      o_dev_protect_base <= 32'h00000000;
      o_handshake_req <= 1'b0;
    end else begin
      if (state_q == ST_PROTECT) begin
        o_dev_protect_en <= 1'b1;
        o_dev_protect_base <= base_q;
      end
      o_handshake_req <= (state_d == ST_HANDSHAKE) && i_multi_proc;
    end
  end

  // ==========================================================
  // Image stream to the module
  // ==========================================================
  // Reads the header word, then streams every image word in order.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      raddr_q <= `SSI_ENTRY_WORD;
      rd_pend_q <= 1'b0;
      sent_q <= 16'h0000;
      entry_q <= 16'h0000;
      len_q <= 16'h0000;
      o_tpm <= '0;
    end else begin
      o_tpm.valid <= 1'b0;
      o_tpm.start <= 1'b0;
      o_tpm.finish <= 1'b0;
      if (state_q == ST_HANDSHAKE) begin
        raddr_q <= (`SSI_RAM_AW)'(base_q[15:2]);
        rd_pend_q <= 1'b0;
        sent_q <= 16'h0000;
      end else if (state_q == ST_HDR) begin
        rd_pend_q <= 1'b1;
        if (rd_pend_q) begin
          entry_q <= rdata[15:0];
          len_q <= rdata[31:16];
          o_tpm.start <= 1'b1;
        end
      end else if (tx_fire) begin
        o_tpm.valid <= 1'b1;
        o_tpm.data <= rdata;
        sent_q <= sent_q + 16'h0004;
        raddr_q <= raddr_q + 1'b1;
        rd_pend_q <= 1'b0;
      end else if (state_q == ST_XFER) begin
        rd_pend_q <= 1'b1;
      end
      if (state_q == ST_SIGNAL && i_tpm_ready) begin
        o_tpm.finish <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Interrupt gate and shutdown
  // ==========================================================
  // Gate closes during startup; set by software wins back delivery.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gate <= 1'b1;
      o_halted <= 1'b0;
      o_irq_held <= 1'b0;
      o_irq_deliver <= 1'b0;
    end else begin
      if (state_q == ST_GATE) begin
        o_gate <= 1'b0;
      end else if (i_gate_set) begin
        o_gate <= 1'b1;
      end
      if (i_shutdown && !o_gate) begin
        o_halted <= 1'b1;
      end
      if (i_irq_req && (!o_gate || state_q != ST_IDLE)) begin
        o_irq_held <= 1'b1;
      end else if (o_gate && state_q == ST_IDLE) begin
        o_irq_held <= 1'b0;
      end
      o_irq_deliver <= o_gate && state_q == ST_IDLE && (o_irq_held || i_irq_req);
    end
  end

  // Status outputs.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_busy <= state_d != ST_IDLE;
      o_done <= state_q == ST_DONE;
    end
  end
endmodule

/* test/secure_startup_props.sv */
// Concurrent checks on the ports of the secure startup sequencer.
`timescale 1ns/10ps
`include "secure_startup_cfg.svh"
module secure_startup_props
  import secure_startup_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_shutdown,
  input wire logic o_jump,
  input wire logic o_gate,
  input wire logic o_halted,
  input wire logic o_irq_deliver,
  input wire logic o_dev_protect_en,
  input wire logic [31:0] o_dev_protect_base,
  input wire logic [31:0] o_accumulator,
  input wire logic [31:0] o_stack_ptr,
  input wire logic [31:0] o_jump_addr,
  input wire logic [31:0] o_data_reg,
  input wire logic [4:0] o_vcr,
  input wire mode_t o_mode,
  input wire tpm_tx_t o_tpm
);
  // ====================
  // Sequence checks.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence s_signal;
    o_tpm.finish;
  endsequence
  sequence s_launch;
    ##[1:8] o_jump;
  endsequence
  property p_stack;
    o_jump |-> o_stack_ptr == o_accumulator + `SSI_BLOCK_SIZE;
  endproperty
  a_stack: assert property (p_stack) else $error("stack top wrong at jump");
  property p_entry;
    o_jump |-> o_jump_addr[31:16] == o_accumulator[31:16] && o_accumulator[15:0] == 16'h0000;
  endproperty
  a_entry: assert property (p_entry) else $error("jump target off block");
  property p_mode;
    o_jump |-> o_mode.code_sel == 16'h0008 && o_mode.stack_sel == 16'h0010 && o_mode.flat32
      && !o_mode.paging && o_mode.data_segs_real16 && o_mode.seg_limit == 32'hFFFFFFFF;
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong at jump");
  property p_regs;
    o_jump |-> !o_gate && o_vcr[2:0] == 3'h7 && o_data_reg == `SSI_MODEL_INFO;
  endproperty
  a_regs: assert property (p_regs) else $error("state wrong at jump");
  property p_base;
    $rose(o_dev_protect_en) |-> o_dev_protect_base[15:0] == 16'h0000;
  endproperty
  a_base: assert property (p_base) else $error("protected base unaligned");
  property p_order;
    o_tpm.valid |-> o_dev_protect_en && o_dev_protect_base == o_accumulator;
  endproperty
  a_order: assert property (p_order) else $error("word sent before protection");
  property p_launch;
    s_signal |-> s_launch;
  endproperty
  a_launch: assert property (p_launch) else $error("no jump after finish");
  property p_halt_hold;
    o_halted |=> o_halted;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left without reset");
  property p_halt;
    i_shutdown && !o_gate |-> ##[1:3] o_halted;
  endproperty
  a_halt: assert property (p_halt) else $error("shutdown did not halt");
  property p_irq;
    !o_gate && !$past(o_gate) |-> !o_irq_deliver;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt passed closed gate");
endmodule
bind secure_startup_seq secure_startup_props u_props (.i_clk_sys, .i_nrst, .i_shutdown,
  .o_jump, .o_gate, .o_halted, .o_irq_deliver, .o_dev_protect_en, .o_dev_protect_base,
  .o_accumulator, .o_stack_ptr, .o_jump_addr, .o_data_reg, .o_vcr, .o_mode, .o_tpm);

/* test/tpm_model.sv */
// Behavioural trusted platform module that stalls and records the streamed image.
`timescale 1ns/10ps
module tpm_model
  import secure_startup_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire tpm_tx_t i_tx,
  input wire logic i_slow,
  output logic o_ready,
  output logic [31:0] o_count,
  output logic [31:0] o_sig,
  output logic o_bad
);
  logic [2:0] cnt_q;
  logic open_q;
  // In slow mode ready is offered one cycle in eight.
  assign o_ready = !i_slow || cnt_q == 3'h5;
  // Words count whether or not a start/finish frame is open; a word or finish outside a frame marks a failed launch.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 3'h0;
      open_q <= 1'b0;
      o_count <= 32'h0;
      o_sig <= 32'h0;
      o_bad <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (i_tx.start) begin
        open_q <= 1'b1;
        o_count <= 32'h0;
        o_sig <= 32'h0;
      end else if (i_tx.valid) begin
        o_bad <= o_bad | !open_q;
        o_count <= o_count + 32'h1;
        o_sig <= {o_sig[30:0], o_sig[31]} ^ i_tx.data;
      end
      if (i_tx.finish) begin
        o_bad <= o_bad | !open_q;
        open_q <= 1'b0;
      end
    end
  end
endmodule

/* test/secure_startup_seq_tb_top.sv */
// Self-checking bench for the secure startup sequencer.
`timescale 1ns/10ps
`include "secure_startup_cfg.svh"
module secure_startup_seq_tb_top
  import secure_startup_pkg::*;
;
  logic clk, nrst = 1'b0, start = 1'b0, mp = 1'b0, hs = 1'b0, we = 1'b0, gset = 1'b0;
  logic vwe = 1'b0, shut = 1'b0, irq = 1'b0, slow = 1'b0, rdy, busy, jmp, pen, hreq;
  logic gate, held, deliv, dpo, a20, ird, halted, bad, done, efc, tsup;
  logic [31:0] gclr;
  int n_efc = 0, n_done = 0;
  logic [13:0] waddr = 14'h0000;
  logic [4:0] vwd = 5'h00, vcr;
  logic [31:0] acc = 32'h0, wdata = 32'h0, acc_o, dreg, sp, ja, cnt, sig, rs = 32'h7C47;
  logic [31:0] exp_q[$];
  tpm_tx_t tx;
  int miscompares = 0, n_tests = 0;
  secure_startup_seq u_secure_startup_seq (.i_clk_sys(clk), .i_nrst(nrst), .i_start(start),
    .i_accumulator(acc), .i_multi_proc(mp), .i_handshake_done(hs), .i_tpm_ready(rdy),
    .i_img_we(we), .i_img_waddr(waddr), .i_img_wdata(wdata), .i_gate_set(gset),
    .i_vcr_we(vwe), .i_vcr_wdata(vwd), .i_shutdown(shut), .i_irq_req(irq), .o_busy(busy),
    .o_done(done), .o_accumulator(acc_o), .o_data_reg(dreg), .o_stack_ptr(sp),
    .o_gpr_clear(gclr), .o_jump_addr(ja), .o_jump(jmp), .o_ext_feature_clear(efc),
    .o_mode(), .o_vcr(vcr),
    .o_dev_protect_en(pen), .o_dev_protect_base(), .o_handshake_req(hreq), .o_tpm(tx),
    .o_gate(gate), .o_irq_held(held), .o_irq_deliver(deliv), .o_debug_port_off(dpo),
    .o_a20_mask_off(a20), .o_init_redirect(ird), .o_halted(halted), .o_trap_suppress(tsup));
  tpm_model u_tpm_model (.i_clk_sys(clk), .i_nrst(nrst), .i_tx(tx), .i_slow(slow),
    .o_ready(rdy), .o_count(cnt), .o_sig(sig), .o_bad(bad));
  // ====================
  // Clock, random source and checking tasks.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counts the one-cycle status pulses on the falling edge, where they are settled.
  always @(negedge clk) begin
    if (efc === 1'b1) n_efc++;
    if (done === 1'b1) n_done++;
  end
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("%0d compares, %0d miscompares", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One launch: preload the image, start twice, and check the hand-off state.
  task automatic run(input int len, input logic mpv, input logic slw, input logic rel);
    logic [31:0] a, w, s, entry, c0;
    int n, k;
    a = rnd();
    c0 = cnt;
    n_efc = 0;
    n_done = 0;
    n = (len + 3) / 4;
    s = 32'h0;
    exp_q = {};
    for (int i = 0; i < n; i++) begin
      w = rnd();
      if (i == 0) w[31:16] = len[15:0];
      if (i == 0) entry = {16'h0000, w[15:0]};
      exp_q.push_back(w);
      @(posedge clk);
      we <= 1'b1;
      waddr <= 14'(i);
      wdata <= w;
    end
    foreach (exp_q[i]) s = {s[30:0], s[31]} ^ exp_q[i];
    @(posedge clk);
    {we, mp, slow, acc, start} <= {1'b0, mpv, slw, a, 1'b1};
    @(posedge clk);
    {start, acc} <= {1'b0, rnd()};
    tick(3);
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    k = 0;
    while (mpv && hreq !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    if (mpv) begin
      tick(20);
      chk(cnt, c0, "word before handshake");
      chk({busy, hreq, tsup}, 3'b111, "handshake asked");
      chk(gclr, 32'hFFFFFFFF, "registers cleared");
    end
    hs <= 1'b1;
    k = 0;
    while (jmp !== 1'b1 && k < 20000) begin
      tick(1);
      k++;
    end
    chk(jmp, 1, "launch");
    chk(tsup, 0, "traps back on");
    chk(gclr, 32'h00000000, "register clear released");
    chk(acc_o, a & `SSI_BLOCK_MASK, "block base");
    chk(pen, 1, "protection");
    chk(sp, (a & `SSI_BLOCK_MASK) + 32'h00010000, "stack");
    chk(ja, (a & `SSI_BLOCK_MASK) + entry, "entry");
    chk(dreg, `SSI_MODEL_INFO, "model info");
    chk(vcr[2:0], 3'h7, "control flags");
    chk(gate, 0, "gate");
    chk(cnt, n, "word count");
    chk(sig, s, "image content");
    chk(bad, 0, "framing");
    hs <= 1'b0;
    irq <= 1'b1;
    tick(3);
    chk({held, deliv}, 2'b10, "interrupt held");
    chk({a20, ird, dpo}, 3'h7, "debug, restart, mask");
    chk(n_efc, 1, "feature clear pulse");
    chk(n_done, 1, "done pulse");
    if (rel) begin
      {gset, vwe, vwd} <= {2'b11, 5'h00};
      tick(1);
      {gset, vwe} <= 2'b00;
      tick(3);
      chk({deliv, gate, vcr}, {2'b11, 5'h00}, "release");
      chk(dpo, 0, "debug on again");
    end
    irq <= 1'b0;
  endtask
  // ====================
  // Main sequence and watchdog.
  initial begin
    tick(2);
    nrst <= 1'b1;
    chk({gate, busy}, 2'b10, "reset state");
    run(8, 1'b0, 1'b0, 1'b1);
    run(13, 1'b1, 1'b1, 1'b1);
    run(1 + (rnd() & 32'h3F), 1'b1, 1'b0, 1'b1);
    run(4, 1'b0, 1'b1, 1'b0);
    n_efc = 0;
    shut <= 1'b1;
    tick(4);
    {shut, start} <= 2'b01;
    tick(1);
    start <= 1'b0;
    tick(4);
    chk({halted, busy}, 2'b10, "halted");
    chk(n_efc, 0, "refused start");
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    chk({halted, gate}, 2'b01, "reset clears halt");
    end_of_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule
